// ==== design/sram_write_strobe_mapper.sv ====
// Purpose: map user write words and strobes onto memory beats and lanes
// Assumes: link clock much slower than core clock, sampled not used as clock
// Notes: each user word goes out as eight beats, one per link clock edge
`timescale 1ns/1ns
module sram_write_strobe_mapper
    import swm_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // configuration
    input wire logic [1:0] memory_data_width_i,
    // user write stream
    input wire logic wr_valid_i,
    input wire swm_wr_t wr_word_i,
    output logic wr_ready_o,
    // link clock from the memory side
    input wire logic link_clk_i,
    // memory beat output
    output logic beat_valid_o,
    output logic [SWM_BUS_W-1:0] data_out_o,
    output logic [SWM_LANES-1:0] byte_lane_select_n_o,
    output logic [SWM_SLICES-1:0] slice_write_n_o,
    output logic [1:0] beat_cycle_o,
    output logic beat_fall_o
);

    // ------------------------------------------------------------
    // slice map
    // ------------------------------------------------------------
    // where slice s of beat k comes from; beats run cycle by cycle,
    // within a cycle the lower listed strobe index first
    function automatic swm_map_t map_slice(input logic [1:0] mode,
                                           input logic [2:0] k,
                                           input logic [1:0] s);
        int kk;
        int ss;
        int c;
        int e;
        int i;
        int j;
        int st;
        swm_map_t m;
        kk = int'(k);
        ss = int'(s);
        c = kk / 2;
        e = kk % 2;
        i = 0;
        st = 0;
        m = '0;
        case (mode)
            SWM_MODE_X36: begin
                i = 8 * (kk % 4) + 2 * ss + kk / 4;
                st = SWM_BUS_W * kk + SWM_SLICE_W * ss;
                m.vld = 1'b1;
                m.lane = 2'(i / 8);
                m.fall = 1'(e);
            end
            SWM_MODE_X18: begin
                j = c + 4 * ss;
                i = j + 8 * e;
                st = 9 * (j / 2) + 72 * (j % 2) + 36 * e;
                m.vld = (ss < 2);
                m.lane = 2'(i / 8);
                m.fall = 1'(e);
            end
            SWM_MODE_X9: begin
                i = c + 4 * e;
                st = 9 * (i / 2) + 36 * (i % 2);
                m.vld = (ss == 0);
                m.lane = 2'h0;
                m.fall = 1'(i % 2);
            end
            // undefined width code maps no slice, so its beats write nothing
            default: begin
                m.vld = 1'b0;
            end
        endcase
        m.idx = 5'(i);
        m.start = 9'(st);
        return m;
    endfunction

    // ------------------------------------------------------------
    // input buffer
    // ------------------------------------------------------------
    logic buf_valid;          // word waiting at the head
    swm_wr_t buf_word;        // head word
    logic pop;                // last beat of head word sent

    swm_fifo #(
        .WIDTH($bits(swm_wr_t)),
        .DEPTH(SWM_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(wr_valid_i),
        .in_data_i(wr_word_i),
        .in_ready_o(wr_ready_o),
        .out_valid_o(buf_valid),
        .out_ready_i(pop),
        .out_data_o(buf_word)
    );

    // ------------------------------------------------------------
    // link clock edges
    // ------------------------------------------------------------
    logic link_meta_ff;       // first stage, read only by second
    logic link_sync_ff;       // synchronised level
    logic link_prev_ff;       // level one core cycle ago
    logic link_rise;
    logic link_fall;

    assign link_rise = link_sync_ff & ~link_prev_ff;
    assign link_fall = ~link_sync_ff & link_prev_ff;

    // two-flop synchroniser and edge history
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_meta_ff <= 1'b0;
            link_sync_ff <= 1'b0;
            link_prev_ff <= 1'b0;
        end else if (clk_en_i) begin
            link_meta_ff <= link_clk_i;
            link_sync_ff <= link_meta_ff;
            link_prev_ff <= link_sync_ff;
        end
    end

    // ------------------------------------------------------------
    // beat sequencer
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SWM_IDLE,
        SWM_SEND
    } swm_state_t;

    swm_state_t state_ff;     // waiting for a word or mid-word
    swm_state_t nxt_state;
    logic [2:0] beat_ff;      // next beat of the head word
    logic [2:0] emit_idx;     // beat being formed now
    logic emit;               // a beat leaves on this edge

    // a word only starts on a rising edge so beat 0 lands on cycle 1 rising
    assign emit_idx = (state_ff == SWM_IDLE) ? SWM_BEAT_FIRST : beat_ff;
    assign emit = (state_ff == SWM_IDLE) ? (link_rise & buf_valid)
                                         : (link_rise | link_fall);
    assign pop = emit & (emit_idx == SWM_BEAT_LAST);

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // start of a word
            SWM_IDLE: begin
                if (emit) begin
                    nxt_state = SWM_SEND;
                end
            end
            // finish after the eighth beat
            SWM_SEND: begin
                if (pop) begin
                    nxt_state = SWM_IDLE;
                end
            end
            default: begin
                nxt_state = SWM_IDLE;
            end
        endcase
    end

    // state and beat counter
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= SWM_IDLE;
            beat_ff <= SWM_BEAT_FIRST;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
            beat_ff <= emit ? emit_idx + 3'h1 : beat_ff;
        end
    end

    // ------------------------------------------------------------
    // beat assembly
    // ------------------------------------------------------------
    swm_map_t slice_map [SWM_SLICES];
    logic [SWM_SLICES-1:0] slice_n;
    logic [SWM_BUS_W-1:0] beat_data;
    logic [SWM_LANES-1:0] lane_n;
    swm_beat_t nxt_beat;

    for (genvar s = 0; s < SWM_SLICES; s++) begin : g_slice
        assign slice_map[s] = map_slice(memory_data_width_i, emit_idx, 2'(s));
        assign beat_data[s*SWM_SLICE_W +: SWM_SLICE_W] = slice_map[s].vld
            ? buf_word.data[slice_map[s].start +: SWM_SLICE_W] : '0;
        // strobes outside the mode never read
        assign slice_n[s] = slice_map[s].vld ? buf_word.strb_n[slice_map[s].idx] : 1'b1;
    end

    // lane low when any of its slices writes
    always_comb begin
        lane_n = SWM_LANES_IDLE;
        lane_n[slice_map[0].lane] = &slice_n;
    end

    // every beat tagged with cycle; x36 and x18 beats also with edge, x9 beats with strobe index parity
    assign nxt_beat.data = beat_data;
    assign nxt_beat.lane_n = lane_n;
    assign nxt_beat.slice_n = slice_n;
    assign nxt_beat.cycle = emit_idx[2:1];
    assign nxt_beat.fall = slice_map[0].fall;

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    swm_beat_t out_beat_ff;   // beat on the pins
    logic beat_vld_ff;        // one-cycle marker per beat

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_beat_ff <= '{data: '0, lane_n: SWM_LANES_IDLE,
                             slice_n: SWM_LANES_IDLE, cycle: 2'h0, fall: 1'b0};
            beat_vld_ff <= 1'b0;
        end else if (clk_en_i) begin
            beat_vld_ff <= emit;
            // selects held until the next beat of the word, cleared once the sequencer is idle
            if (emit) begin
                out_beat_ff <= nxt_beat;
            end else if (state_ff == SWM_IDLE) begin
                out_beat_ff.lane_n <= SWM_LANES_IDLE;
                out_beat_ff.slice_n <= SWM_LANES_IDLE;
            end
        end
    end

    assign beat_valid_o = beat_vld_ff;
    assign data_out_o = out_beat_ff.data;
    assign byte_lane_select_n_o = out_beat_ff.lane_n;
    assign slice_write_n_o = out_beat_ff.slice_n;
    assign beat_cycle_o = out_beat_ff.cycle;
    assign beat_fall_o = out_beat_ff.fall;

endmodule

// ==== design/swm_pkg.sv ====
// Purpose: shared constants and carriers for the write strobe mapper
// Assumes: one beat is one link clock edge, eight beats per user word
// Notes: mode codes select the memory data width of the attached part
package swm_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SWM_WORD_W = 288;       // user write word, 8 beats of 36
    localparam int SWM_STRB_W = 32;        // strobes, 8 per 9-bit slice lane
    localparam int SWM_BUS_W = 36;         // widest memory data bus
    localparam int SWM_SLICE_W = 9;        // bits one strobe qualifies
    localparam int SWM_SLICES = 4;         // slices on the widest bus
    localparam int SWM_LANES = 4;          // byte lane select outputs
    localparam int SWM_BEATS = 8;          // beats per user word
    localparam int SWM_FIFO_DEPTH = 16;    // words buffered ahead of the link

    // ------------------------------------------------------------
    // memory data width modes
    // ------------------------------------------------------------
    localparam logic [1:0] SWM_MODE_X9 = 2'h0;
    localparam logic [1:0] SWM_MODE_X18 = 2'h1;
    localparam logic [1:0] SWM_MODE_X36 = 2'h2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SWM_LANES_IDLE = 4'hF;   // active low, all off
    localparam logic [2:0] SWM_BEAT_FIRST = 3'h0;
    localparam logic [2:0] SWM_BEAT_LAST = 3'h7;

    // user write word with its active-low strobes
    typedef struct packed {
        logic [SWM_STRB_W-1:0] strb_n;
        logic [SWM_WORD_W-1:0] data;
    } swm_wr_t;

    // one beat toward the memory
    typedef struct packed {
        logic [SWM_BUS_W-1:0] data;
        logic [SWM_LANES-1:0] lane_n;      // byte lane selects, active low
        logic [SWM_SLICES-1:0] slice_n;    // per-slice write qualify, active low
        logic [1:0] cycle;                 // memory clock cycle minus one
        logic fall;                        // 1: falling edge beat in x36 and x18, odd strobe index in x9
    } swm_beat_t;

    // where one slice of a beat comes from
    typedef struct packed {
        logic vld;
        logic [4:0] idx;                   // strobe index
        logic [8:0] start;                 // first data bit in the word
        logic [1:0] lane;
        logic fall;
    } swm_map_t;

endpackage

// ==== design/swm_fifo.sv ====
// Purpose: word buffer between user logic and the beat sequencer
// Assumes: single clock, write and read may happen in the same cycle
// Notes: ready toward the source is registered so it comes from a flop
`timescale 1ns/1ns
module swm_fifo
    import swm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_ff [DEPTH];      // word storage
    logic [AW-1:0] wr_ptr_ff;              // next slot to fill
    logic [AW-1:0] rd_ptr_ff;              // oldest word
    logic [AW:0] cnt_ff;                   // words held
    logic rdy_ff;                          // room for one more
    logic push;
    logic pop;
    logic [AW:0] nxt_cnt;

    assign push = in_valid_i & rdy_ff;
    assign pop = out_ready_i & (cnt_ff != '0);
    assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready_o = rdy_ff;
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];

    // storage write, no reset needed on data
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers, count and registered ready
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else if (clk_en_i) begin
            wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            cnt_ff <= nxt_cnt;
            // full counts a push taken now, so no word is ever dropped
            rdy_ff <= (nxt_cnt != (AW+1)'(DEPTH));
        end
    end

endmodule

// ==== verification/swm_link_model.sv ====
// Purpose: link clock source and memory side beat recorder
// Assumes: the link clock is wanted only while words are in flight
// Notes: each period ends low, so the clock stands still when idle
`timescale 1ns/1ns
module swm_link_model
    import swm_pkg::*;
(
    // bench control
    input wire logic core_clk_i,
    input wire logic run_i,
    // beats from the mapper
    input wire logic beat_valid_i,
    input wire logic [SWM_BUS_W-1:0] data_i,
    input wire logic [SWM_LANES-1:0] lane_n_i,
    input wire logic [SWM_SLICES-1:0] slice_n_i,
    input wire logic [1:0] cycle_i,
    input wire logic fall_i,
    // link clock out
    output logic link_clk_o
);
    swm_beat_t got[$]; // beats as the memory saw them

    // 125 ns period; the 1 ns start offset keeps every edge off both core edges
    initial begin
        link_clk_o = 1'h0;
        forever begin
            wait (run_i);
            #1;
            while (run_i) begin
                #62 link_clk_o = 1'h1;
                #63 link_clk_o = 1'h0;
            end
        end
    end

    // one record per one-cycle valid pulse, taken mid-cycle where it is settled
    always @(negedge core_clk_i) begin
        if (beat_valid_i === 1'h1) begin
            got.push_back({data_i, lane_n_i, slice_n_i, cycle_i, fall_i});
        end
    end
endmodule

// ==== verification/swm_checker.sv ====
// Purpose: timing and mapping checks on the beat outputs
// Assumes: link edges at least six core cycles apart
// Notes: the beat counter relies on whole eight-beat words
`timescale 1ns/1ns
module swm_checker
    import swm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [1:0] memory_data_width_i,
    // beat outputs
    input wire logic beat_valid_o,
    input wire logic [SWM_BUS_W-1:0] data_out_o,
    input wire logic [SWM_LANES-1:0] byte_lane_select_n_o,
    input wire logic [SWM_SLICES-1:0] slice_write_n_o,
    input wire logic [1:0] beat_cycle_o,
    input wire logic beat_fall_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [2:0] beat_cnt_ff; // beat position in the word
    wire is_x9 = memory_data_width_i == SWM_MODE_X9;
    wire is_x36 = memory_data_width_i == SWM_MODE_X36;
    wire is_x18 = memory_data_width_i == SWM_MODE_X18;

    // counts beats so each phase can be tied to its place
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            beat_cnt_ff <= SWM_BEAT_FIRST;
        end else if (beat_valid_o && clk_en_i) begin
            beat_cnt_ff <= beat_cnt_ff + 3'h1;
        end
    end

    sequence rise_beat_s;
        beat_valid_o && !beat_fall_o && !is_x9;
    endsequence
    sequence fall_next_s;
        ##[1:10] (beat_valid_o && beat_fall_o);
    endsequence

    chk_lane_onehot: assert property ((byte_lane_select_n_o != 4'hF) |->
        (slice_write_n_o != 4'hF && $onehot(~byte_lane_select_n_o)))
        else $error("lane low without a written slice");
    chk_x36_lane: assert property (beat_valid_o && is_x36 && slice_write_n_o != 4'hF
        |-> byte_lane_select_n_o == ~(4'h1 << {beat_cycle_o[0], beat_fall_o}))
        else $error("wide mode lane wrong");
    chk_x18_lane: assert property (beat_valid_o && is_x18 && slice_write_n_o != 4'hF
        |-> byte_lane_select_n_o == ~(4'h1 << beat_fall_o) && slice_write_n_o[3:2] == 2'h3)
        else $error("half mode lane wrong");
    chk_x9_slice: assert property (beat_valid_o && is_x9 |->
        slice_write_n_o[3:1] == 3'h7 && byte_lane_select_n_o[3:1] == 3'h7
        && data_out_o[35:9] == 27'h0) else $error("narrow mode upper slices used");
    chk_x9_phase: assert property (beat_valid_o && is_x9 |->
        beat_cycle_o == beat_cnt_ff[2:1] && beat_fall_o == beat_cnt_ff[1])
        else $error("narrow mode phase wrong");
    chk_beat_order: assert property (beat_valid_o && (is_x36 || is_x18) |->
        {beat_cycle_o, beat_fall_o} == beat_cnt_ff) else $error("beat phase out of order");
    chk_valid_pulse: assert property (beat_valid_o |=> !beat_valid_o)
        else $error("beat valid longer than one cycle");
    chk_edge_pair: assert property (rise_beat_s |-> fall_next_s)
        else $error("rising beat without its falling beat");
endmodule

bind sram_write_strobe_mapper swm_checker chk_u (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .memory_data_width_i(memory_data_width_i),
    .beat_valid_o(beat_valid_o),
    .data_out_o(data_out_o),
    .byte_lane_select_n_o(byte_lane_select_n_o),
    .slice_write_n_o(slice_write_n_o),
    .beat_cycle_o(beat_cycle_o),
    .beat_fall_o(beat_fall_o)
);

// ==== verification/sram_write_strobe_mapper_test.sv ====
// Purpose: self-checking bench for the write strobe mapper
// Assumes: link clock driven by the model only while words are queued
// Notes: rows cover the widths, then fifo fill and reset mid-word
`timescale 1ns/1ns
module sram_write_strobe_mapper_test
    import swm_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic [31:0] strb_n;
        logic [3:0] lane0_n; // lanes of the first beat
    } swm_row_t;
    logic core_clk, nrst, clk_en, wr_valid, wr_ready, link_clk, link_run;
    logic beat_valid, fall;
    logic [1:0] mode, cycle;
    logic [3:0] lane_n, slice_n;
    logic [35:0] data_out;
    swm_wr_t wr_word, w;
    swm_wr_t fill[16];
    int err_count, checks_done, base, t;
    swm_row_t rows[8] = '{'{SWM_MODE_X36, 32'h0000_0000, 4'hE},
        '{SWM_MODE_X36, 32'hFFFF_FFFE, 4'hE}, '{SWM_MODE_X36, 32'hFFFF_FFFD, 4'hF},
        '{SWM_MODE_X36, 32'h00FF_FFFF, 4'hF}, '{SWM_MODE_X18, 32'hFFFF_0000, 4'hE},
        '{SWM_MODE_X18, 32'h0000_FFFF, 4'hF}, '{SWM_MODE_X9, 32'hFFFF_FF00, 4'hE},
        '{SWM_MODE_X9, 32'h0000_00FF, 4'hF}};

    sram_write_strobe_mapper dut_u (.core_clk_i(core_clk), .nrst_i(nrst), .clk_en_i(clk_en),
        .memory_data_width_i(mode), .wr_valid_i(wr_valid), .wr_word_i(wr_word),
        .wr_ready_o(wr_ready), .link_clk_i(link_clk), .beat_valid_o(beat_valid),
        .data_out_o(data_out), .byte_lane_select_n_o(lane_n), .slice_write_n_o(slice_n),
        .beat_cycle_o(cycle), .beat_fall_o(fall));
    swm_link_model model_u (.core_clk_i(core_clk), .run_i(link_run), .beat_valid_i(beat_valid),
        .data_i(data_out), .lane_n_i(lane_n), .slice_n_i(slice_n), .cycle_i(cycle),
        .fall_i(fall), .link_clk_o(link_clk));

    task automatic final_report;
        $display("tests done: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic fail(string msg);
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask
    // distinct nine-bit slices so a wrong pick shows
    function automatic swm_wr_t mk_word(int seed, logic [31:0] strb);
        swm_wr_t x;
        x.strb_n = strb;
        for (int n = 0; n < 32; n++) x.data[9 * n +: 9] = 9'(n * 7 + seed * 13);
        return x;
    endfunction
    // beat k of a word: every strobe placed forward from its index, cycle and edge
    function automatic swm_beat_t exp_beat(logic [1:0] m, swm_wr_t x, int k);
        swm_beat_t b;
        int n, st, cy, fl, sl;
        b = '0;
        b.lane_n = SWM_LANES_IDLE;
        b.slice_n = 4'hF;
        b.cycle = 2'(k / 2);
        n = (m == SWM_MODE_X36) ? 32 : (m == SWM_MODE_X18) ? 16 : 8;
        for (int i = 0; i < n; i++) begin
            if (m == SWM_MODE_X36) begin
                st = 36 * (i / 8 + 4 * (i % 2)) + 9 * ((i % 8) / 2);
                cy = (i / 8 + 4 * (i % 2)) / 2;
                fl = (i / 8) % 2;
                sl = (i % 8) / 2;
            end else if (m == SWM_MODE_X18) begin
                st = 9 * ((i % 8) / 2) + 72 * (i % 2) + 36 * (i / 8);
                cy = i % 4;
                fl = i / 8;
                sl = (i % 8) / 4;
            end else begin
                st = 9 * (i / 2) + 36 * (i % 2);
                cy = i % 4;
                fl = i % 2;
                sl = 0;
            end
            // narrow mode sends the lower index of a cycle first
            if (cy == k / 2 && ((m == SWM_MODE_X9) ? (i / 4 == k % 2) : (fl == k % 2))) begin
                b.fall = 1'(fl);
                b.data[9 * sl +: 9] = x.data[st +: 9];
                b.slice_n[sl] = x.strb_n[i];
                b.lane_n[i / 8] = b.lane_n[i / 8] & x.strb_n[i];
            end
        end
        return b;
    endfunction
    // holds the word until ready is seen, leaves valid up
    task automatic send(swm_wr_t x);
        wr_word = x;
        wr_valid = 1'h1;
        for (t = 0; wr_ready !== 1'h1 && t < 200; t++) @(negedge core_clk);
        if (t == 200) fail("word never taken");
        @(negedge core_clk);
    endtask
    task automatic run_link(int n);
        link_run = 1'h1;
        for (t = 0; model_u.got.size() < n && t < 3000; t++) @(negedge core_clk);
        link_run = 1'h0;
        if (t == 3000) fail("beats missing");
        repeat (30) @(negedge core_clk);
    endtask
    task automatic chk_word(logic [1:0] m, swm_wr_t x, int b0);
        for (int k = 0; k < 8; k++) begin
            if (model_u.got[b0 + k] !== exp_beat(m, x, k)) fail($sformatf("beat %0d", k));
            checks_done++;
        end
    endtask

    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #300000 fail("watchdog");
        final_report();
    end
    initial begin
        {nrst, wr_valid, link_run, wr_word} = '0;
        clk_en = 1'h1;
        mode = SWM_MODE_X36;
        repeat (4) @(negedge core_clk);
        if (wr_ready !== 1'h0 || beat_valid !== 1'h0 || lane_n !== 4'hF) fail("reset");
        checks_done++;
        nrst = 1'h1;
        for (int r = 0; r < 8; r++) begin
            mode = rows[r].mode;
            w = mk_word(r, rows[r].strb_n);
            base = model_u.got.size();
            send(w);
            wr_valid = 1'h0;
            run_link(base + 8);
            chk_word(rows[r].mode, w, base);
            if (model_u.got[base].lane_n !== rows[r].lane0_n) fail("lane");
            if (lane_n !== SWM_LANES_IDLE) fail("idle lanes");
            checks_done += 2;
        end
        $display("test rows done");
        mode = SWM_MODE_X36;
        base = model_u.got.size();
        for (int r = 0; r < 16; r++) begin
            fill[r] = mk_word(r + 20, 32'h5A5A_A5A5 ^ 32'(r));
            send(fill[r]);
        end
        wr_word = mk_word(99, 32'h0);
        repeat (6) @(negedge core_clk);
        if (wr_ready !== 1'h0) fail("full fifo ready");
        wr_valid = 1'h0;
        run_link(base + 128);
        for (int r = 0; r < 16; r++) chk_word(mode, fill[r], base + 8 * r);
        if (wr_ready !== 1'h1 || model_u.got.size() != base + 128) fail("drain");
        checks_done += 2;
        $display("test fifo done");
        base = model_u.got.size();
        send(mk_word(40, 32'h0));
        wr_valid = 1'h0;
        link_run = 1'h1;
        for (t = 0; model_u.got.size() < base + 3 && t < 500; t++) @(negedge core_clk);
        nrst = 1'h0;
        link_run = 1'h0;
        @(negedge core_clk);
        if (t == 500 || beat_valid !== 1'h0 || {lane_n, slice_n} !== 8'hFF || data_out !== '0) fail("rst");
        checks_done++;
        repeat (30) @(negedge core_clk);
        nrst = 1'h1;
        w = mk_word(41, 32'hF0F0_0F0F);
        base = model_u.got.size();
        send(w);
        wr_valid = 1'h0;
        run_link(base + 8);
        chk_word(mode, w, base);
        $display("test reset mid word done");
        // enable low: link edges pass unseen and the buffered word waits
        base = model_u.got.size();
        send(w);
        wr_valid = 1'h0;
        clk_en = 1'h0;
        link_run = 1'h1;
        repeat (100) @(negedge core_clk);
        link_run = 1'h0;
        repeat (20) @(negedge core_clk);
        if (model_u.got.size() != base || beat_valid !== 1'h0) fail("frozen");
        checks_done++;
        clk_en = 1'h1;
        run_link(base + 8);
        chk_word(mode, w, base);
        $display("test clock enable done");
        final_report();
    end
endmodule
